// ==== logic/mic_interrupt_control.sv ====
/*
  Interrupt controller: flags, enables, core redirection, sleep wake and
  context shadowing, with an APB register slave.
  Assumes the core reports the end of every instruction cycle, that flag
  inputs are one-cycle pulses synchronous to core_clk, and that the core
  executes NOPs while coreStall is high.
*/
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module mic_interrupt_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources
  input wire logic extPin,
  input wire logic timer0Overflow,
  input wire logic [7:0] portBChangeEvent,
  input wire logic timer1GateEvent,
  input wire logic adcEvent,
  input wire logic [1:0] clocklessSource,
  // core handshake
  input wire mic_pkg::mic_core_t core,
  input wire mic_pkg::mic_ctx_t coreCtx,
  output logic coreStall,
  output logic coreAsleep,
  output logic vectorLoad,
  output logic [13:0] vectorPc,
  output logic pushReturn,
  output logic [13:0] returnAddr,
  output logic restoreCtx,
  output mic_pkg::mic_ctx_t restoredCtx
);

  logic [7:0] intCtrl;
  logic [7:0] periphEn1;
  logic [1:0] pir1;
  logic [7:0] portBFlags;
  logic extEdgeSelect;
  logic [1:0] quarter;
  logic extPinLast;
  logic extPending;
  mic_pkg::mic_state_t state;
  mic_pkg::mic_state_t next_state;
  logic [2:0] nopCount;
  logic [1:0] wakeArm;
  logic irqRequest;
  logic wakeRequest;
  logic apbWrite;
  logic apbRead;
  logic shadowWrite;
  logic [2:0] shadowIndex;
  mic_pkg::mic_ctx_t shadowCtx;
  logic enterIsr;
  logic [3:0] slotDec;

  // address to shadow slot decode, used by read and write paths
  function automatic logic [3:0] shadow_slot(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - mic_pkg::ADDR_SHADOW_W;
    if (addr >= mic_pkg::ADDR_SHADOW_W && addr <= mic_pkg::ADDR_SHADOW_PCHI) begin
      shadow_slot = {1'b1, rel[4:2]};
    end else begin
      shadow_slot = 4'h0;
    end
  endfunction

  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && penable && !pwrite;
  // decode once into a net; a function result cannot be bit-selected directly
  assign slotDec = shadow_slot(paddr);
  assign shadowWrite = apbWrite && slotDec[3];
  assign shadowIndex = slotDec[2:0];
  assign enterIsr = (state == mic_pkg::MIC_VECTOR);

  // request: enabled flags, peripherals through group enable, all gated by global
  always_comb begin
    irqRequest = intCtrl[mic_pkg::BIT_GLOBAL_EN] && (
      (intCtrl[mic_pkg::BIT_T0IE] && intCtrl[mic_pkg::BIT_T0IF]) ||
      (intCtrl[mic_pkg::BIT_EXTIE] && intCtrl[mic_pkg::BIT_EXTIF]) ||
      (intCtrl[mic_pkg::BIT_CHG_EN] && intCtrl[mic_pkg::BIT_CHG_FLAG]) ||
      (intCtrl[mic_pkg::BIT_GROUP_EN] && |(periphEn1[7:6] & pir1)));
  end

  // wake needs a clockless source whose enable was set before sleep
  always_comb begin
    wakeRequest = ((intCtrl[mic_pkg::BIT_EXTIE] && intCtrl[mic_pkg::BIT_EXTIF]) ||
      (intCtrl[mic_pkg::BIT_CHG_EN] && intCtrl[mic_pkg::BIT_CHG_FLAG]) ||
      (intCtrl[mic_pkg::BIT_GROUP_EN] && |(periphEn1[7:6] & pir1 & clocklessSource)));
  end

  // quarter-cycle counter, realigned at every instruction boundary
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      quarter <= mic_pkg::Q1;
    end else if (core.cycleEnd) begin
      quarter <= mic_pkg::Q1;
    end else begin
      quarter <= quarter + 2'h1;
    end
  end

  // pin edge detect; the edge is latched and posted into the flag in Q4 or Q1
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      extPinLast <= 1'b0;
      extPending <= 1'b0;
    end else begin
      extPinLast <= extPin;
      if ((extEdgeSelect && extPin && !extPinLast) ||
          (!extEdgeSelect && !extPin && extPinLast)) begin
        extPending <= 1'b1;
      end else if (quarter == mic_pkg::Q4 || quarter == mic_pkg::Q1) begin
        extPending <= 1'b0;
      end
    end
  end

  // interrupt_control: enables by software, flags by hardware with set over clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      intCtrl <= mic_pkg::RST_INT_CTRL;
    end else begin
      if (apbWrite && paddr == mic_pkg::ADDR_INT_CTRL) begin
        intCtrl[7:1] <= pwdata[7:1];
      end
      if (timer0Overflow) begin
        intCtrl[mic_pkg::BIT_T0IF] <= 1'b1;
      end
      if (extPending && (quarter == mic_pkg::Q4 || quarter == mic_pkg::Q1)) begin
        intCtrl[mic_pkg::BIT_EXTIF] <= 1'b1;
      end
      intCtrl[mic_pkg::BIT_CHG_FLAG] <= |portBFlags;
      if (enterIsr) begin
        intCtrl[mic_pkg::BIT_GLOBAL_EN] <= 1'b0;
      end else if (state == mic_pkg::MIC_ISR && core.retIntr) begin
        intCtrl[mic_pkg::BIT_GLOBAL_EN] <= 1'b1;
      end
    end
  end

  // enables of the first peripheral enable register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      periphEn1 <= mic_pkg::RST_PERIPH_EN1;
    end else if (apbWrite && paddr == mic_pkg::ADDR_PERIPH_EN1) begin
      periphEn1 <= pwdata[7:0];
    end
  end

  // peripheral flags and port change flags; an event beats a same-cycle clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pir1 <= 2'h0;
      portBFlags <= mic_pkg::RST_ZERO;
      extEdgeSelect <= 1'b1;
    end else begin
      if (apbWrite && paddr == mic_pkg::ADDR_PIR1) begin
        pir1 <= {timer1GateEvent | pwdata[mic_pkg::BIT_T1G], adcEvent | pwdata[mic_pkg::BIT_ADC]};
      end else begin
        pir1 <= pir1 | {timer1GateEvent, adcEvent};
      end
      if (apbWrite && paddr == mic_pkg::ADDR_PORTB_CHG) begin
        portBFlags <= portBChangeEvent | pwdata[7:0];
      end else begin
        portBFlags <= portBFlags | portBChangeEvent;
      end
      if (apbWrite && paddr == mic_pkg::ADDR_EDGE_SEL) begin
        extEdgeSelect <= pwdata[0];
      end
    end
  end

  // sequencer next state: request sampled at the Q1 boundary of a cycle
  always_comb begin
    next_state = state;
    case (state)
      mic_pkg::MIC_RUN: begin
        if (core.cycleEnd && irqRequest) begin
          next_state = mic_pkg::MIC_FLUSH;
        end else if (core.cycleEnd && core.sleepInstr) begin
          next_state = mic_pkg::MIC_SLEEP;
        end
      end
      mic_pkg::MIC_FLUSH: begin
        if (core.cycleEnd && nopCount == mic_pkg::FLUSH_NOPS) begin
          next_state = mic_pkg::MIC_VECTOR;
        end
      end
      mic_pkg::MIC_VECTOR: next_state = mic_pkg::MIC_ISR;
      mic_pkg::MIC_ISR: begin
        if (core.retIntr) begin
          next_state = mic_pkg::MIC_RUN;
        end
      end
      mic_pkg::MIC_SLEEP: begin
        if (wakeRequest) begin
          next_state = mic_pkg::MIC_WAKE;
        end
      end
      mic_pkg::MIC_WAKE: begin
        if (core.cycleEnd) begin
          next_state = mic_pkg::MIC_RUN;
        end
      end
      default: next_state = mic_pkg::MIC_RUN;
    endcase
  end

  // sequencer state and flush counter; always two NOPs whatever the instruction length
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= mic_pkg::MIC_RUN;
      nopCount <= 3'h0;
    end else begin
      state <= next_state;
      if (state != mic_pkg::MIC_FLUSH) begin
        nopCount <= 3'h1;
      end else if (core.cycleEnd) begin
        nopCount <= nopCount + 3'h1;
      end
    end
  end

  // wake holds until the next instruction retires, so it always runs first
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wakeArm <= 2'h0;
    end else begin
      wakeArm <= {wakeArm[0], state == mic_pkg::MIC_WAKE};
    end
  end

  // core-facing outputs, all registered
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      coreStall <= 1'b0;
      coreAsleep <= 1'b0;
      vectorLoad <= 1'b0;
      vectorPc <= 14'h0000;
      pushReturn <= 1'b0;
      returnAddr <= 14'h0000;
      restoreCtx <= 1'b0;
    end else begin
      coreStall <= (next_state == mic_pkg::MIC_FLUSH);
      coreAsleep <= (next_state == mic_pkg::MIC_SLEEP);
      vectorLoad <= (next_state == mic_pkg::MIC_VECTOR);
      vectorPc <= mic_pkg::VECTOR_ADDR;
      pushReturn <= (next_state == mic_pkg::MIC_VECTOR);
      if (state == mic_pkg::MIC_RUN && next_state == mic_pkg::MIC_FLUSH) begin
        returnAddr <= core.pc;
      end
      restoreCtx <= (state == mic_pkg::MIC_ISR && core.retIntr);
    end
  end

  // shadow copies; the core loads them back on restoreCtx
  mic_shadow_bank shadows (
    .core_clk(core_clk),
    .reset(reset),
    .capture(enterIsr),
    .ctxIn(coreCtx),
    .swWrite(shadowWrite),
    .swIndex(shadowIndex),
    .swData(pwdata[7:0]),
    .ctxOut(shadowCtx)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      restoredCtx <= '0;
    end else begin
      restoredCtx <= shadowCtx;
    end
  end

  // apb: zero wait states, unmapped addresses read zero with an error
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          mic_pkg::ADDR_INT_CTRL: prdata[7:0] <= intCtrl;
          mic_pkg::ADDR_PERIPH_EN1: prdata[7:0] <= periphEn1;
          mic_pkg::ADDR_PIR1: prdata[7:6] <= pir1;
          mic_pkg::ADDR_PORTB_CHG: prdata[7:0] <= portBFlags;
          mic_pkg::ADDR_EDGE_SEL: prdata[0] <= extEdgeSelect;
          mic_pkg::ADDR_STATE: prdata[2:0] <= state;
          default: begin
            if (slotDec[3]) begin
              prdata[7:0] <= shadowCtx[63 - 8 * slotDec[2:0] -: 8];
            end else begin
              pslverr <= 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule

// ==== logic/mic_pkg.sv ====
/*
  Shared constants and types for the microcontroller interrupt controller.
  Assumes a single 200 MHz core clock; one instruction cycle is four quarter ticks.
*/
package mic_pkg;

  // register byte addresses on the APB slave
  localparam logic [7:0] ADDR_INT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIPH_EN1 = 8'h04;
  localparam logic [7:0] ADDR_PIR1 = 8'h08;
  localparam logic [7:0] ADDR_PORTB_CHG = 8'h0C;
  localparam logic [7:0] ADDR_EDGE_SEL = 8'h10;
  localparam logic [7:0] ADDR_SHADOW_W = 8'h14;
  localparam logic [7:0] ADDR_SHADOW_STATUS = 8'h18;
  localparam logic [7:0] ADDR_SHADOW_BANK = 8'h1C;
  localparam logic [7:0] ADDR_SHADOW_PTR0L = 8'h20;
  localparam logic [7:0] ADDR_SHADOW_PTR0H = 8'h24;
  localparam logic [7:0] ADDR_SHADOW_PTR1L = 8'h28;
  localparam logic [7:0] ADDR_SHADOW_PTR1H = 8'h2C;
  localparam logic [7:0] ADDR_SHADOW_PCHI = 8'h30;
  localparam logic [7:0] ADDR_STATE = 8'h34;

  // interrupt_control bit positions
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_GROUP_EN = 6;
  localparam int BIT_T0IE = 5;
  localparam int BIT_EXTIE = 4;
  localparam int BIT_CHG_EN = 3;
  localparam int BIT_T0IF = 2;
  localparam int BIT_EXTIF = 1;
  localparam int BIT_CHG_FLAG = 0;

  // peripheral enable / flag bit positions
  localparam int BIT_T1G = 7;
  localparam int BIT_ADC = 6;

  // shadow slot indices and count
  localparam int SHADOW_COUNT = 8;
  localparam logic [2:0] SH_W = 3'h0;
  localparam logic [2:0] SH_STATUS = 3'h1;
  localparam logic [2:0] SH_BANK = 3'h2;
  localparam logic [2:0] SH_PCHI = 3'h7;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'hE7; // timeout and powerdown bits excluded

  // reset values
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIPH_EN1 = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // timing
  localparam int QUARTERS_PER_CYCLE = 4;
  localparam int CLK_MHZ = 200;
  localparam int QUARTER_NS = 5;
  localparam int QUARTER_CYCLES = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q4 = 2'h3;
  localparam logic [13:0] VECTOR_ADDR = 14'h0004;
  localparam logic [2:0] FLUSH_NOPS = 3'h2;

  typedef enum logic [2:0] {
    MIC_RUN = 3'b000,
    MIC_FLUSH = 3'b001,
    MIC_VECTOR = 3'b010,
    MIC_ISR = 3'b011,
    MIC_SLEEP = 3'b100,
    MIC_WAKE = 3'b101
  } mic_state_t;

  // context the core hands over on entry and takes back on return
  typedef struct packed {
    logic [7:0] work;
    logic [7:0] status;
    logic [7:0] bank;
    logic [7:0] ptr0l;
    logic [7:0] ptr0h;
    logic [7:0] ptr1l;
    logic [7:0] ptr1h;
    logic [7:0] pcHigh;
  } mic_ctx_t;

  // requests from the core toward the controller
  typedef struct packed {
    logic cycleEnd;
    logic sleepInstr;
    logic retIntr;
    logic [13:0] pc;
  } mic_core_t;

endpackage

// ==== logic/mic_shadow_bank.sv ====
/*
  Shadow context storage for interrupt entry and return.
  Assumes capture and software write are never asked in the same cycle;
  capture has priority if they are.
*/
`timescale 1ns/1ps
module mic_shadow_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // hardware save
  input wire logic capture,
  input wire mic_pkg::mic_ctx_t ctxIn,
  // software access
  input wire logic swWrite,
  input wire logic [2:0] swIndex,
  input wire logic [7:0] swData,
  // stored context
  output mic_pkg::mic_ctx_t ctxOut
);

  logic [7:0] slot [mic_pkg::SHADOW_COUNT];
  logic [63:0] flatIn;

  assign flatIn = ctxIn;

  // save all slots on entry, clear status bits that must not travel
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < mic_pkg::SHADOW_COUNT; i++) begin
        slot[i] <= mic_pkg::RST_ZERO;
      end
    end else if (capture) begin
      for (int i = 0; i < mic_pkg::SHADOW_COUNT; i++) begin
        slot[i] <= flatIn[63 - 8 * i -: 8];
      end
      slot[mic_pkg::SH_STATUS] <= ctxIn.status & mic_pkg::STATUS_KEEP_MASK;
    end else if (swWrite) begin
      slot[swIndex] <= swData;
    end
  end

  assign ctxOut = {slot[0], slot[1], slot[2], slot[3], slot[4], slot[5], slot[6], slot[7]};

endmodule

// ==== verif/mic_core_model.sv ====
/*
  Behavioural core facing the interrupt controller.
  Assumes the bench raises return and sleep requests as levels.
*/
`timescale 1ns/1ps
module mic_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bench requests
  input wire logic wantRet,
  input wire logic wantSleep,
  // controller answers
  input wire logic coreStall,
  input wire logic coreAsleep,
  input wire logic vectorLoad,
  input wire logic [13:0] vectorPc,
  // core status
  output mic_pkg::mic_core_t core
);
  logic [1:0] quarter;
  logic [13:0] pc;
  // four quarter ticks per instruction cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      quarter <= 2'h0;
    else
      quarter <= quarter + 2'h1;
  end
  // pc holds during nop fill so the return address stays put
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      pc <= 14'h0100;
    else if (vectorLoad)
      pc <= vectorPc;
    else if (quarter == 2'h3 && !coreStall && !coreAsleep)
      pc <= pc + 14'h0001;
  end
  assign core = {quarter == 2'h3, wantSleep, wantRet, pc};
endmodule

// ==== verif/mic_interrupt_control_asserts.sv ====
/*
  Port checker for the interrupt controller.
  Assumes only the top module ports; bound at the foot of this file.
*/
`timescale 1ns/1ps
module mic_interrupt_control_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire mic_pkg::mic_core_t core,
  input wire logic coreStall,
  input wire logic coreAsleep,
  input wire logic vectorLoad,
  input wire logic [13:0] vectorPc,
  input wire logic pushReturn,
  input wire logic restoreCtx
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (reset);
  // redirection targets the fixed entry and pushes the return together
  AST_VECTOR_TARGET: assert property (vectorLoad |-> vectorPc == 14'h0004 && pushReturn)
    else $error("vector load off target");
  AST_PUSH_PAIRED: assert property (pushReturn |-> vectorLoad)
    else $error("push without vector");
  AST_NOPS_BEFORE: assert property (vectorLoad |-> $past(coreStall))
    else $error("vector without nop fill");
  // a stall that is not a sleep must end in the vector within twelve clocks (three instruction cycles)
  AST_LATENCY: assert property ($rose(coreStall) && !coreAsleep |-> ##[1:12] vectorLoad)
    else $error("vector late");
  AST_WAKE_ORDER: assert property (coreAsleep |-> !vectorLoad)
    else $error("vector while asleep");
  AST_RETURN_CAUSE: assert property (restoreCtx |-> $past(core.retIntr))
    else $error("restore without return");
  AST_RESET_QUIET: assert property ($past(reset) |-> !coreStall && !vectorLoad)
    else $error("activity right after reset");
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("apb answer missing");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_UNMAPPED: assert property (pready && paddr > 8'h34 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  COV_VECTOR: cover property (vectorLoad);
  COV_RETURN: cover property (restoreCtx);
  COV_REFUSED: cover property (pslverr);
endmodule

bind mic_interrupt_control mic_interrupt_control_asserts chk_u (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core), .coreStall(coreStall),
  .coreAsleep(coreAsleep), .vectorLoad(vectorLoad), .vectorPc(vectorPc),
  .pushReturn(pushReturn), .restoreCtx(restoreCtx));

// ==== verif/tb.sv ====
/*
  Self-checking bench for the interrupt controller.
  Assumes the core model beside it and a 200 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic extPin = 1'b0;
  logic timer0Overflow = 1'b0;
  logic [7:0] portBChangeEvent = 8'h00;
  logic timer1GateEvent = 1'b0;
  logic adcEvent = 1'b0;
  logic [1:0] clocklessSource = 2'h3;
  logic wantRet = 1'b0;
  logic wantSleep = 1'b0;
  mic_pkg::mic_core_t core;
  mic_pkg::mic_ctx_t coreCtx = '0;
  mic_pkg::mic_ctx_t restoredCtx;
  logic coreStall, coreAsleep, vectorLoad, pushReturn, restoreCtx, restoreSeen;
  logic [13:0] vectorPc, returnAddr;
  logic [63:0] apbQ[$];
  logic [63:0] ctxQ[$];
  logic [7:0] rnd;
  int badCount = 0;
  int samplesChecked = 0;
  int vecCount = 0;
  int cycles = 0;
  int n;
  int w;

  always #2.5 core_clk = ~core_clk;

  mic_interrupt_control dut_u (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extPin(extPin), .timer0Overflow(timer0Overflow),
    .portBChangeEvent(portBChangeEvent), .timer1GateEvent(timer1GateEvent),
    .adcEvent(adcEvent), .clocklessSource(clocklessSource), .core(core), .coreCtx(coreCtx),
    .coreStall(coreStall), .coreAsleep(coreAsleep), .vectorLoad(vectorLoad),
    .vectorPc(vectorPc), .pushReturn(pushReturn), .returnAddr(returnAddr),
    .restoreCtx(restoreCtx), .restoredCtx(restoredCtx));
  mic_core_model core_u (.core_clk(core_clk), .reset(reset), .wantRet(wantRet),
    .wantSleep(wantSleep), .coreStall(coreStall), .coreAsleep(coreAsleep),
    .vectorLoad(vectorLoad), .vectorPc(vectorPc), .core(core));

  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // one apb transfer, held until ready, then one idle edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    apbQ.push_back({31'h0, exp});
    apb(1'b0, a, 8'h00);
  endtask
  // return from the service routine and wait for the restore pulse
  task automatic ret();
    wantRet <= 1'b1;
    for (w = 0; w < 40 && restoreCtx !== 1'b1; w++) tick(1);
    wantRet <= 1'b0;
    tick(2);
  endtask
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask

  // results are matched against the oldest note; the cycle cap cuts hangs
  always @(posedge core_clk) begin
    cycles++;
    if (vectorLoad === 1'b1) vecCount++;
    if (vectorLoad === 1'b1) check(returnAddr, 64'(core.pc - 14'h0001));
    if (pready === 1'b1 && pwrite === 1'b0) check({pslverr, prdata}, apbQ.pop_front());
    if (restoreSeen === 1'b1) check({restoredCtx.work, restoredCtx.status}, ctxQ.pop_front());
    restoreSeen <= restoreCtx === 1'b1;
    if (cycles == 30000) begin
      badCount++;
      testDone();
    end
  end

  initial begin
    void'($urandom(32'hCE55DA21));
    tick(4);
    reset <= 1'b0;
    tick(1);
    rd(mic_pkg::ADDR_INT_CTRL, 33'h0);
    rd(mic_pkg::ADDR_PERIPH_EN1, 33'h0);
    rd(mic_pkg::ADDR_EDGE_SEL, 33'h1);
    rd(8'h3C, 33'h100000000);
    endTest("reset");
    // flags latch with every enable clear
    timer0Overflow <= 1'b1;
    tick(1);
    timer0Overflow <= 1'b0;
    extPin <= 1'b1;
    tick(4);
    rd(mic_pkg::ADDR_INT_CTRL, 33'h06);
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'h00);
    apb(1'b1, mic_pkg::ADDR_EDGE_SEL, 8'h00);
    extPin <= 1'b0;
    tick(4);
    rd(mic_pkg::ADDR_INT_CTRL, 33'h02);
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'h00);
    extPin <= 1'b1;
    tick(4);
    rd(mic_pkg::ADDR_INT_CTRL, 33'h00);
    apb(1'b1, mic_pkg::ADDR_EDGE_SEL, 8'h01);
    extPin <= 1'b0;
    rnd = 8'($urandom_range(255, 1));
    portBChangeEvent <= rnd;
    tick(1);
    portBChangeEvent <= 8'h00;
    tick(2);
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'h00);
    rd(mic_pkg::ADDR_INT_CTRL, 33'h01);
    rd(mic_pkg::ADDR_PORTB_CHG, {25'h0, rnd});
    apb(1'b1, mic_pkg::ADDR_PORTB_CHG, 8'h00);
    rd(mic_pkg::ADDR_INT_CTRL, 33'h00);
    endTest("flags");
    // entry, shadow edit, return
    coreCtx <= {$urandom, $urandom};
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'h90);
    extPin <= 1'b1;
    n = vecCount;
    for (w = 0; w < 40 && vecCount == n; w++) tick(1);
    check(64'(w >= 8 && w <= 20), 64'h1);
    rd(mic_pkg::ADDR_INT_CTRL, 33'h12);
    rd(mic_pkg::ADDR_SHADOW_W, {25'h0, coreCtx.work});
    rd(mic_pkg::ADDR_SHADOW_STATUS, {25'h0, coreCtx.status & 8'hE7});
    rnd = 8'($urandom);
    apb(1'b1, mic_pkg::ADDR_SHADOW_W, rnd);
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'h10);
    ctxQ.push_back({48'h0, rnd, coreCtx.status & 8'hE7});
    coreCtx <= ~coreCtx;
    ret();
    rd(mic_pkg::ADDR_INT_CTRL, 33'h90);
    endTest("entry");
    // peripheral sources wait for the group enable
    apb(1'b1, mic_pkg::ADDR_PERIPH_EN1, 8'hC0);
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'h80);
    adcEvent <= 1'b1;
    timer1GateEvent <= 1'b1;
    tick(1);
    adcEvent <= 1'b0;
    timer1GateEvent <= 1'b0;
    n = vecCount;
    tick(30);
    check(64'(vecCount - n), 64'h0);
    rd(mic_pkg::ADDR_PIR1, 33'hC0);
    ctxQ.push_back({48'h0, coreCtx.work, coreCtx.status & 8'hE7});
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'hC0);
    tick(30);
    check(64'(vecCount - n), 64'h1);
    apb(1'b1, mic_pkg::ADDR_PIR1, 8'h00);
    ret();
    endTest("group");
    // wake with global enable clear resumes in line
    apb(1'b1, mic_pkg::ADDR_INT_CTRL, 8'h10);
    wantSleep <= 1'b1;
    for (w = 0; w < 40 && coreAsleep !== 1'b1; w++) tick(1);
    wantSleep <= 1'b0;
    extPin <= 1'b0;
    n = vecCount;
    tick(8);
    check(coreAsleep, 1'b1);
    extPin <= 1'b1;
    tick(30);
    check(coreAsleep, 1'b0);
    check(64'(vecCount - n), 64'h0);
    endTest("sleep");
    testDone();
  end
endmodule
